// ---- include/lcio_regs.vh ----
// Purpose: Register map, field positions and reset values of the LED cycle block
// Assumes: Byte-wide register port, 4-bit region timers per group
// Notes:   Definitions only
`ifndef LCIO_REGS_VH
`define LCIO_REGS_VH
`define LCIO_ADDR_SEL0     4'h0
`define LCIO_ADDR_SEL1     4'h1
`define LCIO_ADDR_SEL2     4'h2
`define LCIO_ADDR_FADEON   4'h3
`define LCIO_ADDR_FULLON   4'h4
`define LCIO_ADDR_FADEOFF  4'h5
`define LCIO_ADDR_OFF1     4'h6
`define LCIO_ADDR_OFF2     4'h7
`define LCIO_ADDR_PEAK     4'h8
`define LCIO_ADDR_MODE     4'h9
`define LCIO_ADDR_INIT     4'ha
`define LCIO_ADDR_LAST     4'ha
`define LCIO_CMD_AINC_BIT  4
`define LCIO_RST_SEL       8'h00
`define LCIO_RST_TIME      8'h44
`define LCIO_RST_PEAK      8'hff
`define LCIO_RST_MODE      8'h00
`define LCIO_RST_INIT      8'h00
`define LCIO_INIT_EN_A     3
`define LCIO_INIT_EN_B     7
`define LCIO_MODE_SRC_A    4
`define LCIO_MODE_SRC_B    5
`define LCIO_MODE_ONE_A    6
`define LCIO_MODE_ONE_B    7
`define LCIO_TICK_DIV      16'd3125
`endif

// ---- src/lcio_cycle_gen.v ----
// Purpose: One intensity-cycle generator walking regions A1..E
// Assumes: tick is a one-cycle enable; region times count ticks
// Notes:   Peak level chosen outside
`timescale 1ns/1ns
`default_nettype none
module lcio_cycle_gen (
	input  wire       ref_clk,
	input  wire       sys_rst,
	input  wire       tick,
	input  wire       restart,
	input  wire [2:0] startRegion,
	input  wire [3:0] fadeOnTime,
	input  wire [3:0] fullOnTime,
	input  wire [3:0] fadeOffTime,
	input  wire [3:0] firstOffTime,
	input  wire [3:0] secondOffTime,
	input  wire [3:0] peakLevel,
	output reg  [2:0] region,
	output reg  [3:0] level,
	output reg        regionEnd
);
	reg [3:0] count_q;
	reg [3:0] dur;
	wire      endNow = tick && (count_q >= dur);
	// ------------------------------
	// Region duration and level
	// ------------------------------
	always @* begin
		case (region)
			3'h0, 3'h4: dur = fadeOnTime;
			3'h1, 3'h5: dur = fullOnTime;
			3'h2, 3'h6: dur = fadeOffTime;
			3'h3: dur = firstOffTime;
			default: dur = secondOffTime;
		endcase
	end
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			region    <= 3'h0;
			count_q   <= 4'h0;
			level     <= 4'h0;
			regionEnd <= 1'b0;
		end else begin
			regionEnd <= endNow && !restart;
			if (restart) begin
				region  <= startRegion;
				count_q <= 4'h0;
			end else if (tick) begin
				if (endNow) begin
					region  <= region + 3'h1;
					count_q <= 4'h0;
				end else begin
					count_q <= count_q + 4'h1;
				end
			end
			case (region)
				3'h0, 3'h4: level <= (dur == 4'h0) ? peakLevel :
					((peakLevel > count_q) ? count_q : peakLevel);
				3'h1, 3'h5: level <= peakLevel;
				3'h2, 3'h6: level <= (peakLevel > count_q) ? (peakLevel - count_q) : 4'h0;
				default: level <= 4'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- src/lcio_led_cycle.v ----
// Purpose: Register file, start-point initialisation and one-shot control, seven LEDs
// Assumes: Byte writes arrive as command then data strobes, synchronous to ref_clk
// Notes:   Three bits per LED, one in each selection reg: {sel2,sel1,sel0}; 000 off, 110/111 on
// Function
// - Init bits 0-2 give group A start region; bit 3 restarts A.
// - Init bits 4-6 give group B start region; bit 7 restarts B.
// - Start code 0..7 maps A1,B1,C1,D,A2,B2,C2,E.
// - Writing init immediately puts each enabled group at its start region.
// - One-shot starts at region start and stops at that region's end.
// - At stop, attached outputs detach, holding group A peak level (110) or off.
// - At stop, selection registers 0, 1 and 2 are rewritten to the held state.
// - Generator keeps cycling after one-shot; others may stay attached.
// - Group B one-shot works like group A with its own settings, but its held-on LEDs take group A peak (110).
// - Timing registers 0x03-0x07, peak 0x08; high nibble B, low A.
// - Selection registers sit at 0x00, 0x01, 0x02.
// - Command 0x10 auto-increments; each data byte goes to next address.
// - Reset returns all registers and outputs to defaults.
// - Register 9 bits 6/7 choose one-shot for A/B.
// - Register 9 bits 4/5 choose master level in bits 0-3 as peak.
// - Regions D and E hold zero for their off-times.
`timescale 1ns/1ns
`default_nettype none
`include "lcio_regs.vh"
module lcio_led_cycle #(
	parameter [15:0] TICK_DIV = `LCIO_TICK_DIV
) (
	input  wire       ref_clk,
	input  wire       sys_rst,
	input  wire       cmdStrobe,
	input  wire       dataStrobe,
	input  wire [7:0] wrData,
	input  wire       rdStrobe,
	output reg  [7:0] rdData,
	output wire [6:0] ledOut,
	output wire [6:0] ledOe
);
	reg  [7:0]  regFile_q [0:10];
	reg  [3:0]  ptr_q;
	reg         autoInc_q;
	reg  [15:0] div_q;
	reg  [3:0]  pwm_q;
	reg  [6:0]  ledOn_q;
	reg  [1:0]  oneArmed_q;
	wire        tick = (div_q == 16'h0000);
	wire        initWr = dataStrobe && (ptr_q == `LCIO_ADDR_INIT);
	wire [7:0]  initByte = wrData;
	wire [3:0]  peakA;
	wire [3:0]  peakB;
	wire [2:0]  regionA;
	wire [2:0]  regionB;
	wire [3:0]  levelA;
	wire [3:0]  levelB;
	wire        endA;
	wire        endB;
	wire        stopA;
	wire        stopB;
	wire        restartA = initWr && initByte[`LCIO_INIT_EN_A];
	wire        restartB = initWr && initByte[`LCIO_INIT_EN_B];
	integer     i;
	integer     j;

	// Mode code of LED n from the three selection registers
	function [2:0] ledMode;
		input [7:0] s0;
		input [7:0] s1;
		input [7:0] s2;
		input [2:0] n;
		begin
			ledMode = {s2[n], s1[n], s0[n]};
		end
	endfunction

	// ------------------------------
	// Peak selection
	// ------------------------------
	assign peakA = regFile_q[`LCIO_ADDR_MODE][`LCIO_MODE_SRC_A] ?
		regFile_q[`LCIO_ADDR_MODE][3:0] : regFile_q[`LCIO_ADDR_PEAK][3:0];
	assign peakB = regFile_q[`LCIO_ADDR_MODE][`LCIO_MODE_SRC_B] ?
		regFile_q[`LCIO_ADDR_MODE][3:0] : regFile_q[`LCIO_ADDR_PEAK][7:4];

	// ------------------------------
	// Generators
	// ------------------------------
	lcio_cycle_gen genA (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.tick         (tick),
		.restart      (restartA),
		.startRegion  (initByte[2:0]),
		.fadeOnTime   (regFile_q[`LCIO_ADDR_FADEON][3:0]),
		.fullOnTime   (regFile_q[`LCIO_ADDR_FULLON][3:0]),
		.fadeOffTime  (regFile_q[`LCIO_ADDR_FADEOFF][3:0]),
		.firstOffTime (regFile_q[`LCIO_ADDR_OFF1][3:0]),
		.secondOffTime(regFile_q[`LCIO_ADDR_OFF2][3:0]),
		.peakLevel    (peakA),
		.region       (regionA),
		.level        (levelA),
		.regionEnd    (endA)
	);
	lcio_cycle_gen genB (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.tick         (tick),
		.restart      (restartB),
		.startRegion  (initByte[6:4]),
		.fadeOnTime   (regFile_q[`LCIO_ADDR_FADEON][7:4]),
		.fullOnTime   (regFile_q[`LCIO_ADDR_FULLON][7:4]),
		.fadeOffTime  (regFile_q[`LCIO_ADDR_FADEOFF][7:4]),
		.firstOffTime (regFile_q[`LCIO_ADDR_OFF1][7:4]),
		.secondOffTime(regFile_q[`LCIO_ADDR_OFF2][7:4]),
		.peakLevel    (peakB),
		.region       (regionB),
		.level        (levelB),
		.regionEnd    (endB)
	);

	// One-shot stop: armed by a restart, fires at the end of the start region
	assign stopA = oneArmed_q[0] && endA && regFile_q[`LCIO_ADDR_MODE][`LCIO_MODE_ONE_A];
	assign stopB = oneArmed_q[1] && endB && regFile_q[`LCIO_ADDR_MODE][`LCIO_MODE_ONE_B];

	// ------------------------------
	// Tick divider and PWM counter
	// ------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			div_q <= 16'h0000;
			pwm_q <= 4'h0;
		end else begin
			div_q <= tick ? (TICK_DIV - 16'h0001) : (div_q - 16'h0001);
			pwm_q <= (pwm_q == 4'he) ? 4'h0 : (pwm_q + 4'h1);
		end
	end

	// ------------------------------
	// Register port and one-shot write-back
	// ------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			for (i = 0; i < 11; i = i + 1) begin
				regFile_q[i] <= `LCIO_RST_TIME;
			end
			regFile_q[`LCIO_ADDR_SEL0] <= `LCIO_RST_SEL;
			regFile_q[`LCIO_ADDR_SEL1] <= `LCIO_RST_SEL;
			regFile_q[`LCIO_ADDR_SEL2] <= `LCIO_RST_SEL;
			regFile_q[`LCIO_ADDR_PEAK] <= `LCIO_RST_PEAK;
			regFile_q[`LCIO_ADDR_MODE] <= `LCIO_RST_MODE;
			regFile_q[`LCIO_ADDR_INIT] <= `LCIO_RST_INIT;
			ptr_q      <= 4'h0;
			autoInc_q  <= 1'b0;
			oneArmed_q <= 2'b00;
			rdData     <= 8'h00;
		end else begin
			if (cmdStrobe) begin
				ptr_q     <= wrData[3:0];
				autoInc_q <= wrData[`LCIO_CMD_AINC_BIT];
			end else if (dataStrobe || rdStrobe) begin
				if (autoInc_q) begin
					ptr_q <= (ptr_q >= `LCIO_ADDR_LAST) ? 4'h0 : (ptr_q + 4'h1);
				end
			end
			if (rdStrobe) begin
				rdData <= (ptr_q <= `LCIO_ADDR_LAST) ? regFile_q[ptr_q] : 8'h00;
			end
			if (dataStrobe && (ptr_q <= `LCIO_ADDR_LAST)) begin
				regFile_q[ptr_q] <= wrData;
			end
			// Detach at stop: rewrite the mode of attached LEDs (hardware wins)
			for (i = 0; i < 7; i = i + 1) begin
				if ((stopA && ledMode(regFile_q[0], regFile_q[1], regFile_q[2], i[2:0]) == 3'h2) ||
					(stopB && ledMode(regFile_q[0], regFile_q[1], regFile_q[2], i[2:0]) == 3'h3)) begin
					regFile_q[`LCIO_ADDR_SEL0][i] <= 1'b0;
					regFile_q[`LCIO_ADDR_SEL1][i] <= ledOn_q[i];
					regFile_q[`LCIO_ADDR_SEL2][i] <= ledOn_q[i];
				end
			end
			if (restartA) oneArmed_q[0] <= 1'b1;
			else if (stopA) oneArmed_q[0] <= 1'b0;
			if (restartB) oneArmed_q[1] <= 1'b1;
			else if (stopB) oneArmed_q[1] <= 1'b0;
		end
	end

	// ------------------------------
	// Held final state per LED
	// ------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			ledOn_q <= 7'h00;
		end else begin
			for (j = 0; j < 7; j = j + 1) begin
				case (ledMode(regFile_q[0], regFile_q[1], regFile_q[2], j[2:0]))
					3'h2: ledOn_q[j] <= (levelA != 4'h0);
					3'h3: ledOn_q[j] <= (levelB != 4'h0);
					default: ledOn_q[j] <= ledOn_q[j];
				endcase
			end
		end
	end

	// ------------------------------
	// Open-drain outputs, enable low while driving
	// ------------------------------
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : gLed
			wire [2:0] m = {regFile_q[2][g], regFile_q[1][g], regFile_q[0][g]};
			wire [3:0] lv = (m == 3'h2) ? levelA :
				(m == 3'h3) ? levelB :
				(m == 3'h6) ? peakA :
				(m == 3'h7) ? peakB : 4'h0;
			assign ledOut[g] = 1'b0;
			assign ledOe[g]  = ~(lv > pwm_q);
		end
	endgenerate
endmodule
`default_nettype wire

// ---- sim/lcio_led_cycle_props.sv ----
// Purpose: Port assertions for the LED cycle block
// Assumes: Sync active-high reset, strobes two cycles apart
// Notes:   Bound to lcio_led_cycle
`timescale 1ns/1ns
`default_nettype none
module lcio_led_cycle_chk (
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic       cmdStrobe,
	input wire logic       dataStrobe,
	input wire logic [7:0] wrData,
	input wire logic       rdStrobe,
	input wire logic [7:0] rdData,
	input wire logic [6:0] ledOut,
	input wire logic [6:0] ledOe
);
	// ----
	// Checks
	// ----
	default clocking @(posedge ref_clk); endclocking
	chk_rst_oe_idle: assert property (sys_rst |=> ledOe == 7'h7f)
		else $error("outputs not idle after reset");
	chk_rst_rd_zero: assert property (sys_rst |=> rdData == 8'h00)
		else $error("read data not cleared by reset");
	chk_pin_low: assert property (disable iff (sys_rst) ledOut == 7'h00)
		else $error("open-drain value not low");
	chk_rd_hold: assert property (disable iff (sys_rst) !rdStrobe |=> $stable(rdData))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property (disable iff (sys_rst)
		(cmdStrobe && wrData == 8'h0b) ##2 dataStrobe ##2 rdStrobe |=> rdData == 8'h00)
		else $error("unmapped place not zero");
	chk_time_rw: assert property (disable iff (sys_rst)
		(cmdStrobe && wrData[7:4] == 4'h0 && wrData[3:0] > 4'h2 && wrData[3:0] < 4'h9)
		##2 (dataStrobe && !cmdStrobe) ##2 (rdStrobe && !cmdStrobe) |=> rdData == $past(wrData, 3))
		else $error("timing register lost write");
	chk_auto_inc: assert property (disable iff (sys_rst)
		(cmdStrobe && wrData == 8'h13) ##2 dataStrobe ##2 dataStrobe
		##2 (cmdStrobe && wrData == 8'h04) ##2 rdStrobe |=> rdData == $past(wrData, 5))
		else $error("auto-increment second byte misplaced");
	chk_wrap_zero: assert property (disable iff (sys_rst)
		(cmdStrobe && wrData == 8'h1a) ##2 dataStrobe ##2 dataStrobe
		##2 (cmdStrobe && wrData == 8'h00) ##2 rdStrobe |=> rdData == $past(wrData, 5))
		else $error("pointer did not wrap to zero");
endmodule
bind lcio_led_cycle lcio_led_cycle_chk u_chk (.ref_clk, .sys_rst, .cmdStrobe, .dataStrobe,
	.wrData, .rdStrobe, .rdData, .ledOut, .ledOe);
`default_nettype wire

// ---- sim/lcio_host_model.sv ----
// Purpose: Host side of the register port
// Assumes: One strobe per transfer, taken one edge later
// Notes:   Data lines show the inverse once released
`timescale 1ns/1ns
`default_nettype none
module lcio_host_model (
	input  wire logic       ref_clk,
	output var  logic       cmdStrobe,
	output var  logic       dataStrobe,
	output var  logic       rdStrobe,
	output var  logic [7:0] wrData,
	input  wire logic [7:0] rdData
);
	// ----
	// Transfers: kind 0 command, 1 data, 2 read
	// ----
	initial begin
		{rdStrobe, dataStrobe, cmdStrobe} = 3'b000;
		wrData = 8'h00;
	end
	task xfer(input logic [1:0] k, input logic [7:0] b, output logic [7:0] q);
		@(posedge ref_clk);
		{rdStrobe, dataStrobe, cmdStrobe} <= 3'b001 << k;
		wrData <= b;
		@(posedge ref_clk);
		{rdStrobe, dataStrobe, cmdStrobe} <= 3'b000;
		wrData <= ~b;
		@(negedge ref_clk);
		q = rdData;
	endtask
endmodule
`default_nettype wire

// ---- sim/test_led_cycle_init_oneshot.sv ----
// Purpose: Self-checking bench for the LED cycle block
// Assumes: Tick divider shortened to 4 cycles
// Notes:   Register model tracks pointer and auto-increment
`timescale 1ns/1ns
`default_nettype none
module test_led_cycle_init_oneshot;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	wire         cmdStrobe, dataStrobe, rdStrobe;
	wire  [7:0]  wrData, rdData;
	wire  [6:0]  ledOut, ledOe;
	integer      errors = 0;
	integer      n_checks = 0;
	integer      seed = 32'h2149;
	integer      i, p;
	logic        ai;
	logic [7:0]  m [0:15];
	logic [7:0]  r;
	logic [31:0] d;
	always #5 ref_clk = ~ref_clk;
	lcio_host_model u_host (.ref_clk(ref_clk), .cmdStrobe(cmdStrobe), .dataStrobe(dataStrobe),
		.rdStrobe(rdStrobe), .wrData(wrData), .rdData(rdData));
	lcio_led_cycle #(.TICK_DIV(16'd4)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.cmdStrobe(cmdStrobe), .dataStrobe(dataStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
		.rdData(rdData), .ledOut(ledOut), .ledOe(ledOe));
	// ----
	// Model and tasks
	// ----
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("wrong value %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rst_m;
		for (i = 0; i < 16; i = i + 1)
			m[i] = (i > 2 && i < 8) ? 8'h44 : ((i == 8) ? 8'hff : 8'h00);
	endtask
	task adv;
		if (ai)
			p = (p == 10) ? 0 : p + 1;
	endtask
	task c(input logic [7:0] b);
		u_host.xfer(2'd0, b, r);
		p = b[3:0];
		ai = b[4];
	endtask
	task w(input logic [7:0] b);
		u_host.xfer(2'd1, b, r);
		if (p < 11)
			m[p] = b;
		adv;
	endtask
	task g;
		u_host.xfer(2'd2, 8'h00, r);
		chk(r, (p < 11) ? m[p] : 8'h00);
		adv;
	endtask
	task summarize;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		rst_m;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		c(8'h10);
		repeat (12) g;
		c(8'h0b);
		w(8'h5a);
		g;
		for (i = 3; i < 9; i = i + 1) begin
			d = $random(seed);
			c(i[7:0]);
			w(d[7:0]);
			g;
		end
		d = $random(seed);
		c(8'h13);
		w(d[7:0]);
		w(d[15:8]);
		c(8'h04);
		g;
		$display("register tests done");
		c(8'h10);
		w(8'h02);
		w(8'h03);
		w(8'h00);
		for (i = 0; i < 6; i = i + 1)
			w(i[0] ? 8'hff : 8'h44);
		w(8'hc0);
		c(8'h1a);
		w(8'hb9);
		w(8'h02);
		c(8'h00);
		g;
		repeat (200) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({1'b0, ledOe}, 8'h7e);
		chk({1'b0, ledOut}, 8'h00);
		m[0] = 8'h00;
		m[1] = 8'h01;
		m[2] = 8'h01;
		c(8'h00);
		g;
		c(8'h01);
		g;
		c(8'h02);
		g;
		$display("one-shot test done");
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({1'b0, ledOe}, 8'h7f);
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		rst_m;
		c(8'h10);
		repeat (11) g;
		$display("reset test done");
		summarize;
	end
	initial begin
		#100000;
		errors = errors + 1;
		summarize;
	end
endmodule
`default_nettype wire
